// ### pkg/lts_cfg.svh
// offsets, field positions, reset values and counts of the travel limit block
`ifndef LTS_CFG_SVH
`define LTS_CFG_SVH

// ==========================================================================
// register byte offsets
`define LTS_OFF_CTRL     8'h00
`define LTS_OFF_SRC_A    8'h04
`define LTS_OFF_SRC_B    8'h08
`define LTS_OFF_LOWSPD   8'h0C
`define LTS_OFF_CMDW     8'h10
`define LTS_OFF_ZONE     8'h14
`define LTS_OFF_STATUS   8'h18

// ==========================================================================
// control fields
`define LTS_CTRL_STYPE_LSB  0
`define LTS_CTRL_SLOW_EN    2
`define LTS_CTRL_PSTOP_EN   3
`define LTS_CTRL_EDGE_LSB   4

// ==========================================================================
// reset values
`define LTS_CTRL_RST     8'h0C
`define LTS_SRC_RST      32'h0000_0000
`define LTS_LOWSPD_RST   16'h0000
`define LTS_CMDW_RST     16'hFFFF

// ==========================================================================
// channel counts and indices
`define LTS_NCH          7
`define LTS_NZONE        4
`define LTS_SRC_BITS     8
`define LTS_CH_LIM_FWD   0
`define LTS_CH_LIM_REV   1
`define LTS_CH_ZONE0     2
`define LTS_CH_INHIBIT   6

`endif

// ### pkg/lts_pkg.sv
// types of the travel limit and sensor positioning block
package lts_pkg;

	// ======================================================================
	// source kind of one channel
	typedef enum logic [1:0] {
		LTS_SRC_NONE    = 2'b00,
		LTS_SRC_PIN     = 2'b01,
		LTS_SRC_CMDBIT  = 2'b10
	} lts_src_kind_t;

	// ======================================================================
	// stop type on a limit switch
	typedef enum logic [1:0] {
		LTS_STOP_RAMP   = 2'b00,
		LTS_STOP_FAST   = 2'b01,
		LTS_STOP_FREE   = 2'b10
	} lts_stop_type_t;

endpackage

// ### hw/lts_chan.sv
// one sensor channel: source select, sample and edge detection
`timescale 1ns/100ps
`default_nettype none

module lts_chan
	import lts_pkg::*;
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic [1:0]    kind,
	input  wire logic [3:0]    idx,
	input  wire logic [15:0]   pins,
	input  wire logic [15:0]   cmd,
	output logic               assigned,
	output logic               level,
	output logic               rise,
	output logic               fall
);

	logic level_r;
	logic level_nxt;
	logic prev_r;

	// ======================================================================
	// source select; an unassigned channel idles high, so it never acts
	always_comb begin
		unique case (lts_src_kind_t'(kind))
			LTS_SRC_PIN:    level_nxt = pins[idx];
			LTS_SRC_CMDBIT: level_nxt = cmd[idx];
			default:        level_nxt = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_r <= 1'b1;
			prev_r  <= 1'b1;
		end else begin
			level_r <= level_nxt;
			prev_r  <= level_r;
		end
	end

	assign assigned = (kind == 2'b01) || (kind == 2'b10);
	assign level    = level_r;
	assign rise     = level_r & ~prev_r;
	assign fall     = ~level_r & prev_r;

	// ======================================================================
	// checks
	unassigned_idle_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(kind == 2'b00) [*3] |-> level_r && !rise && !fall)
		else $error("unassigned channel not idle");

	edge_compare_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		rise |-> level_r && !$past(level_r))
		else $error("rise without a 0 to 1 change");

endmodule // lts_chan

`default_nettype wire

// ### hw/lts_top.sv
// travel limit and sensor positioning logic with its APB register slave
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "lts_cfg.svh"

module lts_top
	import lts_pkg::*;
#(
	parameter int FW = 16
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic [15:0]   di_pin,
	input  wire logic          motor_fwd,
	input  wire logic          motor_rev,
	input  wire logic          motor_stopped,
	input  wire logic [FW-1:0] ref_freq,
	output logic [FW-1:0]      freq_ref_out,
	output logic               stop_req,
	output logic [1:0]         stop_type_out,
	output logic               run_fwd_ok,
	output logic               run_rev_ok
);

	localparam int NCH = `LTS_NCH;
	localparam int NZ  = `LTS_NZONE;

	// ======================================================================
	// pin synchronisers: a change counts once stages two and three agree
	logic [15:0] s1_r, s2_r, s3_r, pin_r, pin_nxt;

	always_comb begin
		for (int b = 0; b < 16; b++) begin
			pin_nxt[b] = (s2_r[b] == s3_r[b]) ? s3_r[b] : pin_r[b];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r  <= 16'hFFFF;
			s2_r  <= 16'hFFFF;
			s3_r  <= 16'hFFFF;
			pin_r <= 16'hFFFF;
		end else begin
			s1_r  <= di_pin;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			pin_r <= pin_nxt;
		end
	end

	// ======================================================================
	// registers
	logic [7:0]    ctrl_r, ctrl_nxt;
	logic [31:0]   src_a_r, src_a_nxt, src_b_r, src_b_nxt;
	logic [15:0]   lowspd_r, lowspd_nxt, cmdw_r, cmdw_nxt;
	logic [NZ-1:0] zone_r, zone_nxt;
	logic [31:0]   prdata_r, prdata_nxt;
	logic [63:0]   src_all;
	logic          wr_en, rd_setup, mapped;
	logic [NCH-1:0] ch_asg, ch_lvl, ch_rise, ch_fall;

	assign src_all  = {src_b_r, src_a_r};
	assign wr_en    = psel & penable & pwrite;
	assign rd_setup = psel & ~penable;
	assign mapped   = (paddr <= `LTS_OFF_STATUS) && (paddr[1:0] == 2'b00);
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~mapped;
	assign prdata   = prdata_r;

	// ======================================================================
	// channels: 0/1 limit stops, 2..5 zone sensors, 6 inhibit
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			lts_chan u_chan (
				.pclk     (pclk),
				.presetn  (presetn),
				.kind     (src_all[g*`LTS_SRC_BITS+4 +: 2]),
				.idx      (src_all[g*`LTS_SRC_BITS +: 4]),
				.pins     (pin_r),
				.cmd      (cmdw_r),
				.assigned (ch_asg[g]),
				.level    (ch_lvl[g]),
				.rise     (ch_rise[g]),
				.fall     (ch_fall[g])
			);
		end
	endgenerate

	// ======================================================================
	// limit, zone and speed decisions
	logic          inhibit, slow_en, pstop_en;
	logic          lim_fwd, lim_rev, both_lim, fwd_blk, rev_blk, trig;
	logic          clamp, pend_r, pend_nxt;
	logic          fwd_ok_nxt, rev_ok_nxt, fwd_ok_r, rev_ok_r;
	logic [1:0]    stype_r, stype_nxt;
	logic [FW-1:0] freq_r, freq_nxt, low_fw;
	logic [NZ-1:0] z_set, z_clr;

	assign inhibit  = ch_asg[`LTS_CH_INHIBIT] & ch_lvl[`LTS_CH_INHIBIT];
	assign slow_en  = ctrl_r[`LTS_CTRL_SLOW_EN] & ~inhibit;
	assign pstop_en = ctrl_r[`LTS_CTRL_PSTOP_EN] & ~inhibit;
	assign lim_fwd  = ch_asg[`LTS_CH_LIM_FWD] & ~ch_lvl[`LTS_CH_LIM_FWD];
	assign lim_rev  = ch_asg[`LTS_CH_LIM_REV] & ~ch_lvl[`LTS_CH_LIM_REV];
	assign both_lim = lim_fwd & lim_rev;
	assign fwd_blk  = (lim_fwd | (zone_r[2] & pstop_en)) & ~inhibit;
	assign rev_blk  = (lim_rev | (zone_r[3] & pstop_en)) & ~inhibit;
	assign trig     = (fwd_blk & motor_fwd) | (rev_blk & motor_rev);
	assign clamp    = slow_en & ((zone_r[0] & motor_fwd)
	                | (zone_r[1] & motor_rev));
	assign low_fw   = lowspd_r[FW-1:0];

	// zone set/clear: even index forward, odd reverse
	always_comb begin
		for (int z = 0; z < NZ; z++) begin
			if (ctrl_r[`LTS_CTRL_EDGE_LSB+z]) begin
				z_set[z] = ch_rise[`LTS_CH_ZONE0+z];
				z_clr[z] = ch_fall[`LTS_CH_ZONE0+z];
			end else begin
				z_set[z] = ch_fall[`LTS_CH_ZONE0+z];
				z_clr[z] = ch_rise[`LTS_CH_ZONE0+z];
			end
			if (z % 2 == 0) begin
				z_set[z] = z_set[z] & motor_fwd;
				z_clr[z] = z_clr[z] & motor_rev;
			end else begin
				z_set[z] = z_set[z] & motor_rev;
				z_clr[z] = z_clr[z] & motor_fwd;
			end
		end
	end

	always_comb begin
		pend_nxt  = ~inhibit & (trig | (pend_r & ~motor_stopped));
		stype_nxt = pend_r ? stype_r : ctrl_r[`LTS_CTRL_STYPE_LSB +: 2];
		if (inhibit) begin
			fwd_ok_nxt = 1'b1;
			rev_ok_nxt = 1'b1;
		end else begin
			fwd_ok_nxt = ~fwd_blk & ~pend_nxt & ~both_lim;
			rev_ok_nxt = ~rev_blk & ~pend_nxt & ~both_lim;
		end
		freq_nxt = (clamp && ref_freq > low_fw) ? low_fw : ref_freq;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_r   <= 1'b0;
			stype_r  <= 2'b00;
			fwd_ok_r <= 1'b0;
			rev_ok_r <= 1'b0;
			freq_r   <= '0;
		end else begin
			pend_r   <= pend_nxt;
			stype_r  <= stype_nxt;
			fwd_ok_r <= fwd_ok_nxt;
			rev_ok_r <= rev_ok_nxt;
			freq_r   <= freq_nxt;
		end
	end

	assign stop_req      = pend_r;
	assign stop_type_out = stype_r;
	assign run_fwd_ok    = fwd_ok_r;
	assign run_rev_ok    = rev_ok_r;
	assign freq_ref_out  = freq_r;

	// ======================================================================
	// register writes and read data
	always_comb begin
		ctrl_nxt   = ctrl_r;
		src_a_nxt  = src_a_r;
		src_b_nxt  = src_b_r;
		lowspd_nxt = lowspd_r;
		cmdw_nxt   = cmdw_r;
		zone_nxt   = zone_r;
		prdata_nxt = prdata_r;
		if (wr_en) begin
			unique case (paddr)
				`LTS_OFF_CTRL:   ctrl_nxt   = pwdata[7:0];
				`LTS_OFF_SRC_A:  src_a_nxt  = pwdata;
				`LTS_OFF_SRC_B:  src_b_nxt  = {8'h00, pwdata[23:0]};
				`LTS_OFF_LOWSPD: lowspd_nxt = pwdata[15:0];
				`LTS_OFF_CMDW:   cmdw_nxt   = pwdata[15:0];
				`LTS_OFF_ZONE:   zone_nxt   = pwdata[NZ-1:0];
				default:         ;
			endcase
		end
		// detection runs regardless of inhibit; a hardware set wins
		zone_nxt = z_set | (zone_nxt & ~z_clr);
		if (rd_setup) begin
			unique case (paddr)
				`LTS_OFF_CTRL:   prdata_nxt = {24'h000000, ctrl_r};
				`LTS_OFF_SRC_A:  prdata_nxt = src_a_r;
				`LTS_OFF_SRC_B:  prdata_nxt = src_b_r;
				`LTS_OFF_LOWSPD: prdata_nxt = {16'h0000, lowspd_r};
				`LTS_OFF_CMDW:   prdata_nxt = {16'h0000, cmdw_r};
				`LTS_OFF_ZONE:   prdata_nxt = {28'h0000000, zone_r};
				`LTS_OFF_STATUS: prdata_nxt = {20'h00000, clamp, rev_ok_r,
				                  fwd_ok_r, pend_r, 1'b0, ch_lvl};
				default:         prdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r   <= `LTS_CTRL_RST;
			src_a_r  <= `LTS_SRC_RST;
			src_b_r  <= `LTS_SRC_RST;
			lowspd_r <= `LTS_LOWSPD_RST;
			cmdw_r   <= `LTS_CMDW_RST;
			zone_r   <= '0;
			prdata_r <= 32'h0000_0000;
		end else begin
			ctrl_r   <= ctrl_nxt;
			src_a_r  <= src_a_nxt;
			src_b_r  <= src_b_nxt;
			lowspd_r <= lowspd_nxt;
			cmdw_r   <= cmdw_nxt;
			zone_r   <= zone_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// ======================================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_hit_fwd;
		lim_fwd && !inhibit && motor_fwd;
	endsequence

	sequence s_held_until_still;
		stop_req && !run_fwd_ok;
	endsequence

	stop_on_low_a: assert property (s_hit_fwd |=> stop_req)
		else $error("limit low did not request a stop");

	restart_hold_a: assert property (
		s_hit_fwd ##1 (!motor_stopped && !inhibit) |=> s_held_until_still)
		else $error("restart allowed before standstill");

	both_block_a: assert property (
		both_lim && !inhibit |=> !run_fwd_ok && !run_rev_ok)
		else $error("restart allowed with both stops low");

	stop_type_a: assert property (
		$rose(stop_req) |-> stop_type_out == $past(ctrl_r[1:0]))
		else $error("stop type not taken from control");

	zone_set_a: assert property (
		z_set[0] |=> zone_r[0])
		else $error("forward slowdown edge not held");

	clamp_low_a: assert property (
		clamp |=> freq_ref_out <= $past(low_fw))
		else $error("reference not clamped in slowdown");

	rev_full_a: assert property (
		zone_r[0] && motor_rev && !motor_fwd && !zone_r[1]
		|=> freq_ref_out == $past(ref_freq))
		else $error("reverse travel clamped in forward zone");

	zone_clear_a: assert property (
		zone_r[0] && z_clr[0] && !z_set[0] |=> !zone_r[0])
		else $error("held zone not cleared by opposite edge");

	inhibit_track_a: assert property (
		inhibit && z_set[0] |=> zone_r[0] && freq_ref_out == $past(ref_freq))
		else $error("inhibit lost a zone edge or clamped");

	inhibit_resume_a: assert property (
		inhibit |=> !stop_req && run_fwd_ok && run_rev_ok)
		else $error("inhibit did not release the stop");

endmodule // lts_top

`default_nettype wire

// ### tb/lts_sensor_model.sv
// sensor model: limit and position switch contacts on the input pins
`timescale 1ns/100ps
`default_nettype none

module lts_sensor_model (
	input  wire logic [15:0] closed,
	output logic [15:0]      di_pin
);
	// ======================================================================
	// contacts
	// closed contact reads 1, open contact reads 0
	assign di_pin = closed;
endmodule // lts_sensor_model

`default_nettype wire

// ### tb/lts_top_tb_top.sv
// testbench of the travel limit and sensor positioning block
`timescale 1ns/100ps
`default_nettype none
`include "lts_cfg.svh"

module lts_top_tb_top;
	import lts_pkg::*;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] closed, di_pin, ref_freq, freq_ref_out, lo, hi;
	logic        motor_fwd, motor_rev, motor_stopped;
	logic        stop_req, run_fwd_ok, run_rev_ok;
	logic [1:0]  stop_type_out;
	int          n_mismatch, checks, cyc, k;

	// ======================================================================
	// design and sensors
	lts_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .di_pin(di_pin), .motor_fwd(motor_fwd),
		.motor_rev(motor_rev), .motor_stopped(motor_stopped),
		.ref_freq(ref_freq), .freq_ref_out(freq_ref_out),
		.stop_req(stop_req), .stop_type_out(stop_type_out),
		.run_fwd_ok(run_fwd_ok), .run_rev_ok(run_rev_ok));
	lts_sensor_model u_sens (.closed(closed), .di_pin(di_pin));

	// ======================================================================
	// clock and timeout
	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	// ======================================================================
	// tasks
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic chk(input logic [31:0] got, exp, input string m);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	function automatic logic [31:0] exp_ref(input logic cl);
		if (cl && ref_freq > lo)
			return 32'(lo);
		return 32'(ref_freq);
	endfunction
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task give_verdict;
		if (n_mismatch == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ======================================================================
	// sequence
	initial begin
		presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
		pwdata = 0; closed = 16'hFFFF; motor_fwd = 0; motor_rev = 0;
		motor_stopped = 1; ref_freq = 0; n_mismatch = 0; checks = 0;
		cyc = 0;
		void'($urandom(32'h158B8000));
		lo = 16'($urandom % 32'h4000);
		hi = 16'h8000 | 16'($urandom);
		ref_freq = hi;
		wt(12);
		presetn <= 1;
		apb(0, `LTS_OFF_CTRL, 0);
		chk(q, 32'h0C, "ctrl reset");
		apb(0, `LTS_OFF_CMDW, 0);
		chk(q, 32'hFFFF, "cmdw reset");
		apb(0, 8'h1C, 0);
		chk({30'h0, e, pready}, 32'h3, "unmapped err");
		// limit stops from command bits, every stop type
		apb(1, `LTS_OFF_SRC_A, 32'h2120);
		for (int t = 0; t < 3; t++) begin
			apb(1, `LTS_OFF_CTRL, 32'h0C | t);
			motor_fwd <= 1;
			motor_stopped <= 0;
			apb(1, `LTS_OFF_CMDW, 32'hFFFE);
			wt(4);
			chk(32'(stop_req), 1, "no stop");
			chk(32'(stop_type_out), t, "stop type");
			motor_fwd <= 0;
			motor_stopped <= 1;
			wt(4);
			chk(32'(stop_req), 0, "stop held");
			chk(32'(run_fwd_ok), 0, "fwd allowed");
			chk(32'(run_rev_ok), 1, "rev refused");
			apb(1, `LTS_OFF_CMDW, 32'hFFFF);
		end
		apb(1, `LTS_OFF_CMDW, 32'hFFFC);
		wt(4);
		chk({30'h0, run_fwd_ok, run_rev_ok}, 0, "both low");
		apb(1, `LTS_OFF_SRC_B, 32'h0022_0000);
		wt(4);
		chk({30'h0, run_fwd_ok, run_rev_ok}, 3, "inhibit");
		apb(1, `LTS_OFF_CMDW, 32'hFFF8);
		wt(4);
		chk({30'h0, run_fwd_ok, run_rev_ok}, 0, "inhibit off");
		apb(1, `LTS_OFF_SRC_A, 0);
		apb(1, `LTS_OFF_SRC_B, 0);
		apb(1, `LTS_OFF_CMDW, 32'hFFFF);
		// forward slowdown zone on a random pin, falling edge
		k = $urandom % 16;
		apb(1, `LTS_OFF_LOWSPD, {16'h0, lo});
		apb(1, `LTS_OFF_CTRL, 32'h0C);
		apb(1, `LTS_OFF_SRC_A, (32'h10 | k) << 16);
		motor_fwd <= 1;
		motor_stopped <= 0;
		wt(10);
		chk(32'(freq_ref_out), 32'(hi), "clamp early");
		closed[k] <= 0;
		wt(10);
		chk(32'(freq_ref_out), 32'(lo), "no clamp");
		apb(0, `LTS_OFF_ZONE, 0);
		chk(q & 1, 1, "zone lost");
		motor_fwd <= 0;
		motor_rev <= 1;
		wt(3);
		chk(32'(freq_ref_out), 32'(hi), "rev clamped");
		closed[k] <= 1;
		wt(10);
		apb(0, `LTS_OFF_ZONE, 0);
		chk(q & 1, 0, "zone kept");
		// rising edge configuration
		apb(1, `LTS_OFF_CTRL, 32'h1C);
		motor_rev <= 0;
		motor_fwd <= 1;
		closed[k] <= 0;
		wt(10);
		chk(32'(freq_ref_out), 32'(hi), "fall fired");
		closed[k] <= 1;
		wt(10);
		chk(32'(freq_ref_out), 32'(lo), "rise missed");
		// zone save and restore
		apb(1, `LTS_OFF_ZONE, 0);
		wt(3);
		chk(32'(freq_ref_out), 32'(hi), "zone clear");
		apb(1, `LTS_OFF_ZONE, 1);
		wt(3);
		chk(32'(freq_ref_out), 32'(lo), "zone restore");
		// inhibit on command bit 3: zones tracked, no clamp
		apb(1, `LTS_OFF_SRC_B, 32'h0023_0000);
		wt(3);
		chk(32'(freq_ref_out), exp_ref(0), "inhibit clamped");
		motor_fwd <= 0;
		motor_rev <= 1;
		closed[k] <= 0;
		wt(10);
		apb(0, `LTS_OFF_ZONE, 0);
		chk(q & 1, 0, "inhibit lost clear");
		motor_rev <= 0;
		motor_fwd <= 1;
		closed[k] <= 1;
		wt(10);
		chk(32'(freq_ref_out), exp_ref(0), "inhibit slowed");
		apb(0, `LTS_OFF_ZONE, 0);
		chk(q & 1, 1, "inhibit lost set");
		apb(1, `LTS_OFF_CMDW, 32'hFFF7);
		wt(3);
		chk(32'(freq_ref_out), exp_ref(1), "clamp lost");
		// slowdown off, sensor stop on command bit 4 still acts
		apb(1, `LTS_OFF_CTRL, 32'h18);
		wt(3);
		chk(32'(freq_ref_out), exp_ref(0), "slowdown not off");
		apb(1, `LTS_OFF_SRC_B, 32'h0023_0024);
		apb(1, `LTS_OFF_CMDW, 32'hFFE7);
		wt(4);
		chk({30'h0, stop_req, run_fwd_ok}, 2, "no sensor stop");
		give_verdict();
	end
endmodule // lts_top_tb_top

`default_nettype wire
